// ---- eeprom_ctrl_consts.svh ----
// offsets, field positions, reset values and timing counts of the data eeprom controller
`ifndef EEPROM_CTRL_CONSTS_SVH
`define EEPROM_CTRL_CONSTS_SVH

// control/status register
`define CSR_OFFSET      8'h2c
`define CSR_RESET       8'h00
`define CSR_IE_BIT      2
`define CSR_LAT_BIT     1
`define CSR_PGM_BIT     0
`define UNMAPPED_RDATA  8'h00

// staging latches and cell array
`define LATCH_COUNT     16
`define LATCH_RESET     8'hff
`define ERASED_BYTE     8'hff
`define ARRAY_BYTES     256

// programming cycle lengths in cpu clocks
`define ERASE_CYCLES    16'h2710
`define PROG_CYCLES     16'h2710

`endif

// ---- eeprom_ctrl_pkg.sv ----
// types shared by the data eeprom controller modules
package eeprom_ctrl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ERASE = 3'b010,
        ST_PROG  = 3'b100
    } prog_state_e;

    typedef struct packed {
        logic ie;
        logic lat;
        logic program_start;
    } csr_s;

    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] data;
    } stage_wr_s;

    typedef struct packed {
        logic [3:0]   row;
        logic [15:0]  mask;
        logic [127:0] data;
    } row_op_s;

endpackage

// ---- eeprom_stage_latches.sv ----
// sixteen write staging latches with and-accumulation and a valid mask
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_ctrl_consts.svh"

module eeprom_stage_latches (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    // capture and clear
    input  wire logic                     wr_en,
    input  wire eeprom_ctrl_pkg::stage_wr_s wr,
    input  wire logic                     clear,
    // contents towards the cell array only
    output logic [127:0]                  data,
    output logic [15:0]                   mask
);

    genvar i;
    generate
        for (i = 0; i < `LATCH_COUNT; i = i + 1) begin : g_latch
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    data[i*8 +: 8] <= `LATCH_RESET;
                    mask[i]        <= 1'b0;
                end else if (clear) begin
                    data[i*8 +: 8] <= `LATCH_RESET;
                    mask[i]        <= 1'b0;
                end else if (wr_en && (wr.idx == 4'(i))) begin
                    // repeated writes accumulate as and
                    data[i*8 +: 8] <= data[i*8 +: 8] & wr.data;
                    mask[i]        <= 1'b1;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ---- eeprom_cell_array.sv ----
// 256 byte cell array: asynchronous read, row erase and row program
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_ctrl_consts.svh"

module eeprom_cell_array (
    // clock
    input  wire logic                    clk,
    // read port
    input  wire logic [7:0]              rd_addr,
    output logic [7:0]                   rd_data,
    // row operations
    input  wire logic                    erase_en,
    input  wire logic                    prog_en,
    input  wire eeprom_ctrl_pkg::row_op_s op
);

    logic [7:0] cells [0:`ARRAY_BYTES-1];

    assign rd_data = cells[rd_addr];

    // cells hold their contents through reset
    always_ff @(posedge clk) begin
        for (int i = 0; i < `LATCH_COUNT; i++) begin
            if (op.mask[i]) begin
                if (erase_en) begin
                    cells[{op.row, 4'(i)}] <= `ERASED_BYTE;
                end else if (prog_en) begin
                    cells[{op.row, 4'(i)}] <= cells[{op.row, 4'(i)}] & op.data[i*8 +: 8];
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- eeprom_write_ctrl.sv ----
// data eeprom controller: rom-like reads, staged writes, self-timed programming
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_ctrl_consts.svh"

module eeprom_write_ctrl #(
    parameter logic [15:0] ERASE_CYCLES = `ERASE_CYCLES,
    parameter logic [15:0] PROG_CYCLES  = `PROG_CYCLES
) (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    // register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic [7:0]      REG_RDATA,
    // eeprom memory bus
    input  wire logic [7:0] MEM_ADDR,
    input  wire logic [7:0] MEM_WDATA,
    input  wire logic       MEM_WR,
    input  wire logic       MEM_RD,
    output logic [7:0]      MEM_RDATA,
    output logic            MEM_RDATA_OE_N,
    // interrupt
    output logic            DONE_IRQ,
    input  wire logic       VECTOR_FETCH,
    // power saving
    input  wire logic       WAIT_REQ,
    output logic            WAIT_ACK,
    input  wire logic       HALT_REQ,
    output logic            HALTED
);

    eeprom_ctrl_pkg::csr_s        csr_r;
    eeprom_ctrl_pkg::csr_s        csr_nxt;
    eeprom_ctrl_pkg::prog_state_e state_r;
    eeprom_ctrl_pkg::prog_state_e state_nxt;
    eeprom_ctrl_pkg::stage_wr_s   stage_wr;
    eeprom_ctrl_pkg::row_op_s     row_op;

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [3:0]  row_r;
    logic        irq_r;
    logic        wait_r;
    logic        halt_r;
    logic [7:0]  rdata_r;

    logic        csr_wr;
    logic        csr_rd;
    logic        pgm_start;
    logic        sw_abort;
    logic        abort;
    logic        erase_last;
    logic        prog_last;
    logic        done;
    logic        lat_fall;
    logic        stage_en;
    logic        latch_clear;
    logic [127:0] latch_data;
    logic [15:0]  latch_mask;
    logic [7:0]   cell_rdata;

    // last cycle of a timed step, shared by erase and program
    function automatic logic step_end(
        input logic [15:0] cnt,
        input logic [15:0] len
    );
        step_end = (cnt == len - 16'h0001);
    endfunction

    // register image with the reserved bits forced low
    function automatic logic [7:0] csr_word(input eeprom_ctrl_pkg::csr_s c);
        csr_word = {5'h00, c.ie, c.lat, c.program_start};
    endfunction

    // register decode
    always_comb begin
        csr_wr = 1'b0;
        csr_rd = 1'b0;
        if (REG_ADDR == `CSR_OFFSET) begin
            csr_wr = REG_WR;
            csr_rd = REG_RD;
        end
    end

    // programming start and abort requests
    always_comb begin
        // start needs staging on, now or in the same write
        pgm_start = csr_wr && REG_WDATA[`CSR_PGM_BIT] && !csr_r.program_start && !HALT_REQ
                    && (csr_r.lat || REG_WDATA[`CSR_LAT_BIT]);
        // early clear of program: cells left undefined
        sw_abort  = csr_wr && !REG_WDATA[`CSR_PGM_BIT] && csr_r.program_start;
        // halt abandons the running cycle at once
        abort     = csr_r.program_start && (sw_abort || HALT_REQ);
    end

    // step timing
    always_comb begin
        erase_last = (state_r == eeprom_ctrl_pkg::ST_ERASE) && step_end(cnt_r, ERASE_CYCLES);
        prog_last  = (state_r == eeprom_ctrl_pkg::ST_PROG) && step_end(cnt_r, PROG_CYCLES);
        done       = prog_last && !abort;
    end

    // sequencer: erase step then program step with no software timing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            eeprom_ctrl_pkg::ST_IDLE: begin
                cnt_nxt = 16'h0000;
                if (pgm_start) begin
                    state_nxt = eeprom_ctrl_pkg::ST_ERASE;
                end
            end
            eeprom_ctrl_pkg::ST_ERASE: begin
                if (abort) begin
                    state_nxt = eeprom_ctrl_pkg::ST_IDLE;
                    cnt_nxt   = 16'h0000;
                end else if (erase_last) begin
                    state_nxt = eeprom_ctrl_pkg::ST_PROG;
                    cnt_nxt   = 16'h0000;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            eeprom_ctrl_pkg::ST_PROG: begin
                if (abort || prog_last) begin
                    state_nxt = eeprom_ctrl_pkg::ST_IDLE;
                    cnt_nxt   = 16'h0000;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            default: begin
                state_nxt = eeprom_ctrl_pkg::ST_IDLE;
                cnt_nxt   = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= eeprom_ctrl_pkg::ST_IDLE;
            cnt_r   <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // control/status next value
    always_comb begin
        csr_nxt = csr_r;
        if (csr_wr) begin
            csr_nxt.ie = REG_WDATA[`CSR_IE_BIT];
            if (REG_WDATA[`CSR_LAT_BIT]) begin
                csr_nxt.lat = 1'b1;
            end else if (!csr_r.program_start) begin
                csr_nxt.lat = 1'b0;
            end
        end
        if (done || abort) begin
            csr_nxt.program_start = 1'b0;
        end else if (pgm_start) begin
            csr_nxt.program_start = 1'b1;
        end
        if (done) begin
            csr_nxt.program_start = 1'b0;
            csr_nxt.lat = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            csr_r <= '0;
        end else begin
            csr_r <= csr_nxt;
        end
    end

    // end-of-cycle request: a set in the clearing cycle wins
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_r <= 1'b0;
        end else if (done && csr_r.ie) begin
            irq_r <= 1'b1;
        end else if (VECTOR_FETCH) begin
            irq_r <= 1'b0;
        end
    end

    assign DONE_IRQ = irq_r;

    // staging capture
    always_comb begin
        lat_fall     = csr_r.lat && !csr_nxt.lat;
        latch_clear  = done || lat_fall;
        // writes with staging off or during a cycle are dropped
        stage_en     = MEM_WR && csr_r.lat && !csr_r.program_start && !HALT_REQ;
        stage_wr.idx  = MEM_ADDR[3:0];
        stage_wr.data = MEM_WDATA;
    end

    // row follows the most recent staged write
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            row_r <= 4'h0;
        end else if (stage_en) begin
            row_r <= MEM_ADDR[7:4];
        end
    end

    eeprom_stage_latches u_latches (
        .clk    (CLK),
        .arst_n (ARST_N),
        .wr_en  (stage_en),
        .wr     (stage_wr),
        .clear  (latch_clear),
        .data   (latch_data),
        .mask   (latch_mask)
    );

    always_comb begin
        row_op.row  = row_r;
        row_op.mask = latch_mask;
        row_op.data = latch_data;
    end

    eeprom_cell_array u_cells (
        .clk      (CLK),
        .rd_addr  (MEM_ADDR),
        .rd_data  (cell_rdata),
        .erase_en (erase_last && !abort),
        .prog_en  (done),
        .op       (row_op)
    );

    // read path: latches have no route to the bus
    assign MEM_RDATA      = cell_rdata;
    assign MEM_RDATA_OE_N = !(MEM_RD && !csr_r.lat);

    // register read data, one cycle after the strobe
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_r <= 8'h00;
        end else if (csr_rd) begin
            rdata_r <= csr_word(csr_r);
        end else if (REG_RD) begin
            rdata_r <= `UNMAPPED_RDATA;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign REG_RDATA = rdata_r;

    // wait waits for the running cycle to finish
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= WAIT_REQ && (state_nxt == eeprom_ctrl_pkg::ST_IDLE);
        end
    end

    assign WAIT_ACK = wait_r;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            halt_r <= 1'b0;
        end else begin
            halt_r <= HALT_REQ;
        end
    end

    assign HALTED = halt_r;

endmodule
`default_nettype wire

// ---- eeprom_write_ctrl_checker.sv ----
// port assertions for the data eeprom controller
`timescale 1ns/10ps
`default_nettype none
module eeprom_write_ctrl_checker #(
    parameter logic [15:0] ERASE_CYCLES = 16'h0004,
    parameter logic [15:0] PROG_CYCLES  = 16'h0005
) (
    // clock and reset
    input wire logic       CLK,
    input wire logic       ARST_N,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    // eeprom bus
    input wire logic       MEM_RD,
    input wire logic       MEM_RDATA_OE_N,
    // interrupt and power
    input wire logic       DONE_IRQ,
    input wire logic       VECTOR_FETCH,
    input wire logic       WAIT_REQ,
    input wire logic       WAIT_ACK,
    input wire logic       HALT_REQ,
    input wire logic       HALTED
);
    localparam int DONE_LO = ERASE_CYCLES + PROG_CYCLES;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    unmapped_rd_a: assert property (REG_RD && REG_ADDR != 8'h2c |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    csr_reserved_a: assert property ($past(REG_RD) |-> REG_RDATA[7:3] == 5'h00)
        else $error("reserved bits not zero");
    oe_idle_a: assert property (!MEM_RD |-> MEM_RDATA_OE_N)
        else $error("data bus driven without read");
    irq_hold_a: assert property (DONE_IRQ && !VECTOR_FETCH |=> DONE_IRQ)
        else $error("request dropped before fetch");
    irq_clear_a: assert property (DONE_IRQ && VECTOR_FETCH |=> !DONE_IRQ)
        else $error("request kept after fetch");
    wait_cause_a: assert property (WAIT_ACK |-> $past(WAIT_REQ))
        else $error("wait without request");
    halt_follow_a: assert property ($rose(HALT_REQ) |=> HALTED)
        else $error("halt not entered");
    halt_noirq_a: assert property (HALT_REQ && !DONE_IRQ |=> !DONE_IRQ)
        else $error("request raised in halt");
    done_time_a: assert property (REG_WR && REG_ADDR == 8'h2c && REG_WDATA == 8'h07 && !HALT_REQ
        |-> ##DONE_LO !DONE_IRQ ##1 DONE_IRQ)
        else $error("cycle end request mistimed");
endmodule

bind eeprom_write_ctrl eeprom_write_ctrl_checker #(
    .ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
    .CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_RD(MEM_RD),
    .MEM_RDATA_OE_N(MEM_RDATA_OE_N), .DONE_IRQ(DONE_IRQ), .VECTOR_FETCH(VECTOR_FETCH),
    .WAIT_REQ(WAIT_REQ), .WAIT_ACK(WAIT_ACK), .HALT_REQ(HALT_REQ), .HALTED(HALTED));
`default_nettype wire

// ---- cpu_bus_model.sv ----
// cpu side of the eeprom memory bus
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
    // clock
    input  wire logic       clk,
    // eeprom bus
    output logic [7:0]      mem_addr,
    output logic [7:0]      mem_wdata,
    output logic            mem_wr,
    output logic            mem_rd,
    input  wire logic [7:0] mem_rdata,
    input  wire logic       mem_rdata_oe_n,
    // interrupt
    output logic            vector_fetch
);
    initial begin
        mem_addr = 8'h00;
        mem_wdata = 8'h00;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        vector_fetch = 1'b0;
    end
    // callers keep the upper nibble per batch
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        mem_addr  <= a;
        mem_wdata <= d;
        mem_wr    <= 1'b1;
        @(posedge clk);
        mem_wr    <= 1'b0;
        mem_wdata <= ~d;
    endtask
    // data reads only, never an instruction fetch
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic o);
        @(posedge clk);
        mem_addr <= a;
        mem_rd   <= 1'b1;
        @(posedge clk);
        d = mem_rdata;
        o = mem_rdata_oe_n;
        mem_rd   <= 1'b0;
    endtask
    task automatic vec();
        @(posedge clk);
        vector_fetch <= 1'b1;
        @(posedge clk);
        vector_fetch <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- eeprom_write_ctrl_tb_top.sv ----
// self-checking bench for the data eeprom controller
`timescale 1ns/10ps
`default_nettype none
module eeprom_write_ctrl_tb_top;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       wait_req = 1'b0;
    logic       halt_req = 1'b0;
    logic [7:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, d;
    logic       mem_wr, mem_rd, oe_n, done_irq, vec, wait_ack, halted, o;
    int         err_total = 0;
    int         tests_run = 0;
    logic [7:0] rows [5][2] = '{'{8'h04, 8'h04}, '{8'hf8, 8'h00}, '{8'h01, 8'h00},
                                '{8'h06, 8'h06}, '{8'h02, 8'h02}};

    always #10 clk = ~clk;

    eeprom_write_ctrl #(.ERASE_CYCLES(16'h0004), .PROG_CYCLES(16'h0005)) u_dut (
        .CLK(clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .MEM_ADDR(mem_addr),
        .MEM_WDATA(mem_wdata), .MEM_WR(mem_wr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata),
        .MEM_RDATA_OE_N(oe_n), .DONE_IRQ(done_irq), .VECTOR_FETCH(vec),
        .WAIT_REQ(wait_req), .WAIT_ACK(wait_ack), .HALT_REQ(halt_req), .HALTED(halted));
    cpu_bus_model u_cpu (
        .clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_rdata_oe_n(oe_n), .vector_fetch(vec));

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rw(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rr(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask
    task automatic await(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n == 100) begin
            err_total++;
            results();
        end
    endtask

    initial begin
        // reset at start and again while idle, never mid-cycle
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rr(8'h2c, d);
        chk8(d, 8'h00);
        rr(8'h2d, d);
        chk8(d, 8'h00);
        foreach (rows[i]) begin
            rw(8'h2c, rows[i][0]);
            rr(8'h2c, d);
            chk8(d, rows[i][1]);
        end
        $display("test csr done");
        rw(8'h2c, 8'h06);
        u_cpu.rd(8'h35, d, o);
        chk1(o, 1'b1);
        u_cpu.wr(8'h35, 8'h5a);
        u_cpu.wr(8'h35, 8'hf0);
        u_cpu.wr(8'h3a, 8'hc3);
        rw(8'h2c, 8'h07);
        rw(8'h2c, 8'h05);
        rr(8'h2c, d);
        chk8(d, 8'h07);
        await(done_irq);
        rr(8'h2c, d);
        chk8(d, 8'h04);
        u_cpu.rd(8'h35, d, o);
        chk8(d, 8'h50);
        chk1(o, 1'b0);
        u_cpu.rd(8'h3a, d, o);
        chk8(d, 8'hc3);
        chk1(done_irq, 1'b1);
        u_cpu.vec();
        @(negedge clk);
        chk1(done_irq, 1'b0);
        $display("test program done");
        rw(8'h2c, 8'h00);
        u_cpu.wr(8'h35, 8'h00);
        rw(8'h2c, 8'h02);
        u_cpu.wr(8'h36, 8'h11);
        rw(8'h2c, 8'h03);
        wait_req <= 1'b1;
        repeat (3) @(negedge clk);
        chk1(wait_ack, 1'b0);
        await(wait_ack);
        wait_req <= 1'b0;
        rr(8'h2c, d);
        chk8(d, 8'h00);
        chk1(done_irq, 1'b0);
        u_cpu.rd(8'h35, d, o);
        chk8(d, 8'h50);
        u_cpu.rd(8'h36, d, o);
        chk8(d, 8'h11);
        $display("test wait done");
        rw(8'h2c, 8'h02);
        u_cpu.wr(8'h37, 8'h22);
        rw(8'h2c, 8'h03);
        halt_req <= 1'b1;
        repeat (2) @(posedge clk);
        chk1(halted, 1'b1);
        halt_req <= 1'b0;
        rr(8'h2c, d);
        chk8(d, 8'h02);
        chk1(done_irq, 1'b0);
        $display("test halt done");
        u_cpu.wr(8'h35, 8'h0f);
        rw(8'h2c, 8'h00);
        rw(8'h2c, 8'h02);
        u_cpu.wr(8'h3a, 8'h3c);
        rw(8'h2c, 8'h07);
        await(done_irq);
        u_cpu.rd(8'h35, d, o);
        chk8(d, 8'h50);
        u_cpu.rd(8'h3a, d, o);
        chk8(d, 8'h3c);
        $display("test latch clear done");
        // reset while idle only, no cycle running
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rr(8'h2c, d);
        chk8(d, 8'h00);
        chk1(done_irq, 1'b0);
        $display("test reset done");
        results();
    end
endmodule
`default_nettype wire
